// File: mctl_pkg.sv
// package: constants, encodings and state layout of the two-channel memory controller
package mctl_pkg;
  localparam int MCTL_QD = 4;
  localparam int MCTL_NCH = 2;
  localparam int MCTL_NSLOT = 4;
  localparam int MCTL_DW = 64;
  localparam logic [7:0] MCTL_REG_CTRL = 8'h00;
  localparam logic [7:0] MCTL_REG_SLOT = 8'h04;
  localparam logic [7:0] MCTL_REG_CAP = 8'h08;
  localparam logic [7:0] MCTL_REG_SEED = 8'h0C;
  localparam logic [7:0] MCTL_REG_STAT = 8'h10;
  localparam int MCTL_CTRL_FAST = 0;
  localparam int MCTL_CTRL_2N = 1;
  localparam int MCTL_CTRL_SWAP = 2;
  localparam int MCTL_CTRL_EN = 3;
  localparam int MCTL_CTRL_W = 4;
  localparam int MCTL_SLOT_W = 4;
  localparam int MCTL_SLOT_PRES = 0;
  localparam int MCTL_SLOT_FAST = 1;
  localparam int MCTL_SLOT_LAT = 2;
  localparam int MCTL_CAP_W = 12;
  localparam int MCTL_CAPB_LO = 16;
  localparam int MCTL_IL_BIT = 6;
  localparam int MCTL_COL_LO = 3;
  localparam int MCTL_BANK_LO = 13;
  localparam int MCTL_ROW_LO = 16;
  localparam int MCTL_WORD_LO = 3;
  localparam logic [4:0] MCTL_CL_1066 = 5'h7;
  localparam logic [4:0] MCTL_RCD_1066 = 5'h7;
  localparam logic [4:0] MCTL_RP_1066 = 5'h7;
  localparam logic [4:0] MCTL_CWL_1066 = 5'h6;
  localparam logic [4:0] MCTL_CL_1333 = 5'h9;
  localparam logic [4:0] MCTL_RCD_1333 = 5'h9;
  localparam logic [4:0] MCTL_RP_1333 = 5'h9;
  localparam logic [4:0] MCTL_CWL_1333 = 5'h7;
  localparam logic [4:0] MCTL_ONE = 5'h1;
  localparam logic [19:0] MCTL_MB_PAD = 20'h0;
  localparam logic [20:0] MCTL_SYM_PAD = 21'h0;
  typedef enum logic [2:0] {
    MCTL_CMD_NOP = 3'b000,
    MCTL_CMD_ACT = 3'b001,
    MCTL_CMD_RD = 3'b010,
    MCTL_CMD_WR = 3'b011,
    MCTL_CMD_PRE = 3'b100
  } mctl_cmd_type;
  typedef enum logic [1:0] {
    MCTL_ST_IDLE = 2'b00,
    MCTL_ST_PRE = 2'b01,
    MCTL_ST_ACT = 2'b10,
    MCTL_ST_DATA = 2'b11
  } mctl_st_type;
  typedef struct packed {
    logic [MCTL_CTRL_W-1:0] ctrl;
    logic [MCTL_NSLOT*MCTL_SLOT_W-1:0] slots;
    logic [MCTL_CAP_W-1:0] cap_a;
    logic [MCTL_CAP_W-1:0] cap_b;
    logic [31:0] seed;
    logic [31:0] rdata;
    logic [MCTL_QD-1:0] qv;
    logic [MCTL_QD-1:0] qbusy;
    logic [MCTL_QD-1:0] qwr;
    logic [MCTL_QD-1:0] qch;
    logic [MCTL_QD-1:0][31:0] qoff;
    logic [MCTL_QD-1:0][MCTL_DW-1:0] qdat;
    logic [MCTL_QD-1:0][3:0] qtag;
    logic [MCTL_QD-1:0][MCTL_QD-1:0] qold;
    mctl_st_type [MCTL_NCH-1:0] st;
    logic [MCTL_NCH-1:0][4:0] tmr;
    logic [MCTL_NCH-1:0][1:0] slot;
    logic [MCTL_NCH-1:0] open;
    logic [MCTL_NCH-1:0][18:0] page;
    logic [MCTL_NCH-1:0] hold;
    mctl_cmd_type [MCTL_NCH-1:0] cmd;
    logic [MCTL_NCH-1:0][2:0] bank;
    logic [MCTL_NCH-1:0][15:0] row;
    logic [MCTL_NCH-1:0][9:0] col;
    logic [MCTL_NCH-1:0][MCTL_DW-1:0] dq;
    logic [MCTL_NCH-1:0] oe;
    logic [MCTL_NCH-1:0] rv;
    logic [MCTL_NCH-1:0][MCTL_DW-1:0] rd;
    logic [MCTL_NCH-1:0][3:0] rt;
  } mctl_state_type;
  localparam mctl_state_type MCTL_STATE_RST = '0;
endpackage

// File: mctl_two_channel_ctrl.sv
// two-channel memory controller core: mapping, scheduling, timing and data scrambling
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
module mctl_two_channel_ctrl
  import mctl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [31:0] req_addr,
  input wire logic [MCTL_DW-1:0] req_wdata,
  input wire logic [3:0] req_tag,
  output logic req_ready,
  output logic [MCTL_NCH-1:0] resp_valid,
  output logic [MCTL_NCH-1:0][MCTL_DW-1:0] resp_data,
  output logic [MCTL_NCH-1:0][3:0] resp_tag,
  output logic [MCTL_NCH-1:0][2:0] ch_cmd,
  output logic [MCTL_NCH-1:0][2:0] ch_bank,
  output logic [MCTL_NCH-1:0][15:0] ch_row,
  output logic [MCTL_NCH-1:0][9:0] ch_col,
  output logic [MCTL_NCH-1:0][MCTL_DW-1:0] ch_dq_out,
  output logic [MCTL_NCH-1:0] ch_dq_oe,
  input wire logic [MCTL_NCH-1:0][MCTL_DW-1:0] ch_dq_in
);

  mctl_state_type s_r;
  mctl_state_type s_nxt;
  logic [MCTL_NSLOT-1:0] present;
  logic [MCTL_NCH-1:0] chpop;
  logic [MCTL_NCH-1:0] l2n;
  logic [MCTL_NCH-1:0][1:0] extra;
  logic [MCTL_NCH-1:0][4:0] cl_c;
  logic [MCTL_NCH-1:0][4:0] cwl_c;
  logic [4:0] rcd_c;
  logic [4:0] rp_c;
  logic fast;
  logic single;
  logic single_ch;
  logic swap;
  logic accept;
  logic [1:0] free_i;
  logic free_v;
  logic [32:0] map_r;
  logic [MCTL_QD-1:0] blk;
  logic [MCTL_NCH-1:0][MCTL_QD-1:0] elig;
  logic [MCTL_NCH-1:0][MCTL_QD-1:0] hitv;
  logic [MCTL_NCH-1:0] gnt_v;
  logic [MCTL_NCH-1:0] gnt_hit;
  logic [MCTL_NCH-1:0][1:0] gnt_i;
  logic [MCTL_NCH-1:0][1:0] cur;
  logic [MCTL_NCH-1:0][MCTL_DW-1:0] key;
  logic [MCTL_NCH-1:0] wr_ahead;

  // xorshift of seed and channel offset; reads recompute it from the stored offset
  function automatic logic [63:0] mctl_key(input logic [31:0] seed, input logic [31:0] off);
    logic [63:0] x;
    x = {seed ^ off, off ^ ~seed};
    x = x ^ (x << 13);
    x = x ^ (x >> 7);
    x = x ^ (x << 17);
    return x;
  endfunction

  // returns {channel, channel offset}; row and column use fixed bits whatever the density
  function automatic logic [32:0] mctl_map(input logic [31:0] a, input logic sg,
      input logic sgc, input logic sw, input logic [MCTL_CAP_W-1:0] cb);
    logic [32:0] r;
    if (sg) begin
      r = {sgc, a};
    end else if ({1'b0, a} < {cb, MCTL_SYM_PAD}) begin
      r = {a[MCTL_IL_BIT] ^ sw, 1'b0, a[31:MCTL_IL_BIT+1], a[MCTL_IL_BIT-1:0]};
    end else begin
      r = {sw, a - {cb, MCTL_MB_PAD}};
    end
    return r;
  endfunction

  always_comb begin
    fast = s_r.ctrl[MCTL_CTRL_FAST];
    for (int k = 0; k < MCTL_NSLOT; k++) begin
      present[k] = s_r.slots[k*MCTL_SLOT_W+MCTL_SLOT_PRES];
      if (present[k] && !s_r.slots[k*MCTL_SLOT_W+MCTL_SLOT_FAST]) begin
        fast = 1'b0;
      end
    end
    rcd_c = fast ? MCTL_RCD_1333 : MCTL_RCD_1066;
    rp_c = fast ? MCTL_RP_1333 : MCTL_RP_1066;
    for (int c = 0; c < MCTL_NCH; c++) begin
      chpop[c] = present[2*c] | present[2*c+1];
      l2n[c] = s_r.ctrl[MCTL_CTRL_2N] | (present[2*c] & present[2*c+1]);
      extra[c] = '0;
      for (int k = 2*c; k < 2*c+2; k++) begin
        if (present[k] && s_r.slots[k*MCTL_SLOT_W+MCTL_SLOT_LAT +: 2] > extra[c]) begin
          extra[c] = s_r.slots[k*MCTL_SLOT_W+MCTL_SLOT_LAT +: 2];
        end
      end
      cl_c[c] = (fast ? MCTL_CL_1333 : MCTL_CL_1066) + {3'b000, extra[c]};
      cwl_c[c] = (fast ? MCTL_CWL_1333 : MCTL_CWL_1066) + {3'b000, extra[c]};
    end
  end

  // dual organisation only once both channels hold a module
  assign single = chpop != 2'b11;
  assign single_ch = chpop[1] & ~chpop[0];
  assign swap = s_r.ctrl[MCTL_CTRL_SWAP];
  assign map_r = mctl_map(req_addr, single, single_ch, swap, s_r.cap_b);

  always_comb begin
    free_v = 1'b0;
    free_i = '0;
    for (int i = MCTL_QD-1; i >= 0; i--) begin
      if (!s_r.qv[i]) begin
        free_v = 1'b1;
        free_i = 2'(i);
      end
    end
  end

  assign req_ready = free_v & s_r.ctrl[MCTL_CTRL_EN];
  assign accept = req_valid & req_ready;

  always_comb begin
    for (int i = 0; i < MCTL_QD; i++) begin
      blk[i] = 1'b0;
      for (int j = 0; j < MCTL_QD; j++) begin
        if (s_r.qold[i][j] && s_r.qv[j] && s_r.qch[i] == s_r.qch[j] &&
            s_r.qoff[i][31:MCTL_WORD_LO] == s_r.qoff[j][31:MCTL_WORD_LO] &&
            (s_r.qwr[i] || s_r.qwr[j])) begin
          blk[i] = 1'b1;
        end
      end
    end
    for (int c = 0; c < MCTL_NCH; c++) begin
      gnt_v[c] = 1'b0;
      gnt_hit[c] = 1'b0;
      gnt_i[c] = '0;
      cur[c] = s_r.slot[c];
      key[c] = mctl_key(s_r.seed, s_r.qoff[cur[c]]);
      for (int i = 0; i < MCTL_QD; i++) begin
        elig[c][i] = s_r.qv[i] & ~s_r.qbusy[i] & (s_r.qch[i] == c[0]) & ~blk[i];
        hitv[c][i] = elig[c][i] & s_r.open[c] &
                     (s_r.qoff[i][31:MCTL_BANK_LO] == s_r.page[c]);
      end
      for (int i = 0; i < MCTL_QD; i++) begin
        if (hitv[c][i] && !gnt_hit[c]) begin
          gnt_v[c] = 1'b1;
          gnt_hit[c] = 1'b1;
          gnt_i[c] = 2'(i);
        end
      end
      if (!gnt_hit[c]) begin
        for (int i = 0; i < MCTL_QD; i++) begin
          if (elig[c][i] && !(|(elig[c] & s_r.qold[i]))) begin
            gnt_v[c] = 1'b1;
            gnt_i[c] = 2'(i);
          end
        end
      end
    end
  end

  // older write still queued for the word a channel works on; kept apart from the grant logic
  always_comb begin
    for (int c = 0; c < MCTL_NCH; c++) begin
      wr_ahead[c] = 1'b0;
      for (int j = 0; j < MCTL_QD; j++) begin
        if (s_r.qold[cur[c]][j] && s_r.qv[j] && s_r.qwr[j] &&
            s_r.qch[j] == s_r.qch[cur[c]] &&
            s_r.qoff[j][31:MCTL_WORD_LO] == s_r.qoff[cur[c]][31:MCTL_WORD_LO]) begin
          wr_ahead[c] = 1'b1;
        end
      end
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = '0;
    s_nxt.oe = '0;
    s_nxt.rv = '0;
    if (reg_we) begin
      if (reg_addr == MCTL_REG_CTRL) begin
        s_nxt.ctrl = reg_wdata[MCTL_CTRL_W-1:0];
      end else if (reg_addr == MCTL_REG_SLOT) begin
        s_nxt.slots = reg_wdata[MCTL_NSLOT*MCTL_SLOT_W-1:0];
      end else if (reg_addr == MCTL_REG_CAP) begin
        s_nxt.cap_a = reg_wdata[MCTL_CAP_W-1:0];
        s_nxt.cap_b = reg_wdata[MCTL_CAPB_LO +: MCTL_CAP_W];
      end else if (reg_addr == MCTL_REG_SEED) begin
        s_nxt.seed = reg_wdata;
      end
    end
    if (reg_re) begin
      if (reg_addr == MCTL_REG_CTRL) begin
        s_nxt.rdata = {28'h0, s_r.ctrl};
      end else if (reg_addr == MCTL_REG_SLOT) begin
        s_nxt.rdata = {16'h0, s_r.slots};
      end else if (reg_addr == MCTL_REG_CAP) begin
        s_nxt.rdata = {4'h0, s_r.cap_b, 4'h0, s_r.cap_a};
      end else if (reg_addr == MCTL_REG_SEED) begin
        s_nxt.rdata = s_r.seed;
      end else if (reg_addr == MCTL_REG_STAT) begin
        // capacity error flags a software slip; hardware keeps running regardless
        s_nxt.rdata = {20'h0, s_r.qv, chpop, s_r.cap_a < s_r.cap_b,
                       ~single & (s_r.cap_a == s_r.cap_b), single, l2n, fast};
      end
    end
    // channels run apart: one may launch while the other waits for data
    for (int c = 0; c < MCTL_NCH; c++) begin
      s_nxt.cmd[c] = MCTL_CMD_NOP;
      case (s_r.st[c])
        MCTL_ST_IDLE: begin
          if (gnt_v[c] && !s_r.hold[c]) begin
            s_nxt.qbusy[gnt_i[c]] = 1'b1;
            s_nxt.slot[c] = gnt_i[c];
            s_nxt.tmr[c] = '0;
            if (gnt_hit[c]) begin
              s_nxt.st[c] = MCTL_ST_ACT;
            end else if (s_r.open[c]) begin
              s_nxt.cmd[c] = MCTL_CMD_PRE;
              s_nxt.bank[c] = s_r.page[c][2:0];
              s_nxt.open[c] = 1'b0;
              s_nxt.tmr[c] = rp_c - MCTL_ONE;
              s_nxt.st[c] = MCTL_ST_PRE;
            end else begin
              s_nxt.st[c] = MCTL_ST_PRE;
            end
          end
        end
        MCTL_ST_PRE: begin
          if (s_r.tmr[c] != '0) begin
            s_nxt.tmr[c] = s_r.tmr[c] - MCTL_ONE;
          end else if (!s_r.hold[c]) begin
            s_nxt.cmd[c] = MCTL_CMD_ACT;
            s_nxt.bank[c] = s_r.qoff[cur[c]][MCTL_BANK_LO +: 3];
            s_nxt.row[c] = s_r.qoff[cur[c]][MCTL_ROW_LO +: 16];
            s_nxt.open[c] = 1'b1;
            s_nxt.page[c] = s_r.qoff[cur[c]][31:MCTL_BANK_LO];
            s_nxt.tmr[c] = rcd_c - MCTL_ONE;
            s_nxt.st[c] = MCTL_ST_ACT;
          end
        end
        MCTL_ST_ACT: begin
          if (s_r.tmr[c] != '0) begin
            s_nxt.tmr[c] = s_r.tmr[c] - MCTL_ONE;
          end else if (!s_r.hold[c]) begin
            s_nxt.cmd[c] = s_r.qwr[cur[c]] ? MCTL_CMD_WR : MCTL_CMD_RD;
            s_nxt.bank[c] = s_r.qoff[cur[c]][MCTL_BANK_LO +: 3];
            s_nxt.col[c] = s_r.qoff[cur[c]][MCTL_COL_LO +: 10];
            s_nxt.tmr[c] = (s_r.qwr[cur[c]] ? cwl_c[c] : cl_c[c]) - MCTL_ONE;
            s_nxt.st[c] = MCTL_ST_DATA;
          end
        end
        default: begin
          if (s_r.tmr[c] != '0) begin
            s_nxt.tmr[c] = s_r.tmr[c] - MCTL_ONE;
          end else begin
            if (s_r.qwr[cur[c]]) begin
              s_nxt.dq[c] = s_r.qdat[cur[c]] ^ key[c];
              s_nxt.oe[c] = 1'b1;
            end else begin
              s_nxt.rd[c] = ch_dq_in[c] ^ key[c];
              s_nxt.rt[c] = s_r.qtag[cur[c]];
              s_nxt.rv[c] = 1'b1;
            end
            s_nxt.qv[cur[c]] = 1'b0;
            s_nxt.qbusy[cur[c]] = 1'b0;
            for (int k = 0; k < MCTL_QD; k++) begin
              s_nxt.qold[k][cur[c]] = 1'b0;
            end
            s_nxt.st[c] = MCTL_ST_IDLE;
          end
        end
      endcase
      // second-clock launch: a command blocks the very next cycle
      s_nxt.hold[c] = (s_nxt.cmd[c] != MCTL_CMD_NOP) & l2n[c];
    end
    if (accept) begin
      s_nxt.qv[free_i] = 1'b1;
      s_nxt.qbusy[free_i] = 1'b0;
      s_nxt.qwr[free_i] = req_write;
      s_nxt.qch[free_i] = map_r[32];
      s_nxt.qoff[free_i] = map_r[31:0];
      s_nxt.qdat[free_i] = req_wdata;
      s_nxt.qtag[free_i] = req_tag;
      s_nxt.qold[free_i] = s_nxt.qv & ~(MCTL_QD'(1) << free_i);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r <= MCTL_STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign resp_valid = s_r.rv;
  assign resp_data = s_r.rd;
  assign resp_tag = s_r.rt;
  assign ch_cmd = s_r.cmd;
  assign ch_bank = s_r.bank;
  assign ch_row = s_r.row;
  assign ch_col = s_r.col;
  assign ch_dq_out = s_r.dq;
  assign ch_dq_oe = s_r.oe;

  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_single_route: assert property ((accept && single && chpop != 2'b00) |->
      chpop[map_r[32]])
    else $error("single-channel request sent to an empty channel");
  a_line_interleave: assert property ((accept && !single &&
      {1'b0, req_addr} < {s_r.cap_b, MCTL_SYM_PAD}) |->
      map_r[32] == (req_addr[MCTL_IL_BIT] ^ swap))
    else $error("interleaved line on wrong channel");

  for (genvar g = 0; g < MCTL_NCH; g++) begin : g_chk
    sequence s_no_rw;
      (s_r.cmd[g] != MCTL_CMD_RD && s_r.cmd[g] != MCTL_CMD_WR)[*6];
    endsequence
    sequence s_no_act;
      (s_r.cmd[g] != MCTL_CMD_ACT)[*6];
    endsequence
    a_launch_gap: assert property ((s_r.cmd[g] != MCTL_CMD_NOP && l2n[g]) |=>
        s_r.cmd[g] == MCTL_CMD_NOP)
      else $error("command launched on consecutive clocks in second-clock mode");
    a_act_to_rw: assert property ((s_r.cmd[g] == MCTL_CMD_ACT) |-> ##1 s_no_rw)
      else $error("read or write too soon after activate");
    a_pre_to_act: assert property ((s_r.cmd[g] == MCTL_CMD_PRE) |-> ##1 s_no_act)
      else $error("activate too soon after precharge");
    a_read_cl7: assert property ((s_r.cmd[g] == MCTL_CMD_RD &&
        cl_c[g] == MCTL_CL_1066) |-> ##7 s_r.rv[g])
      else $error("read data not returned at latency 7");
    a_read_cl9: assert property ((s_r.cmd[g] == MCTL_CMD_RD &&
        cl_c[g] == MCTL_CL_1333) |-> ##9 s_r.rv[g])
      else $error("read data not returned at latency 9");
    a_write_cwl6: assert property ((s_r.cmd[g] == MCTL_CMD_WR &&
        cwl_c[g] == MCTL_CWL_1066) |-> ##6 s_r.oe[g])
      else $error("write data not driven at write latency 6");
    a_page_hit_fast: assert property ((s_r.st[g] == MCTL_ST_IDLE && gnt_v[g] &&
        gnt_hit[g] && !s_r.hold[g]) |->
        ##2 (s_r.cmd[g] == MCTL_CMD_RD || s_r.cmd[g] == MCTL_CMD_WR))
      else $error("open-page hit not issued back to back");
    a_grant_order: assert property ((s_r.cmd[g] == MCTL_CMD_RD) |-> !wr_ahead[g])
      else $error("read issued ahead of older same-address write");
  end

endmodule

// File: mctl_dram_model.sv
// behavioural model of the memory modules on both channels
`timescale 1ns/1ps
module mctl_dram_model
  import mctl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [MCTL_NCH-1:0][2:0] ch_cmd,
  input wire logic [MCTL_NCH-1:0][2:0] ch_bank,
  input wire logic [MCTL_NCH-1:0][15:0] ch_row,
  input wire logic [MCTL_NCH-1:0][9:0] ch_col,
  input wire logic [MCTL_NCH-1:0][MCTL_DW-1:0] ch_dq_out,
  input wire logic [MCTL_NCH-1:0] ch_dq_oe,
  input wire logic [MCTL_NCH-1:0][4:0] cl,
  output logic [MCTL_NCH-1:0][MCTL_DW-1:0] ch_dq_in
);
  logic [MCTL_DW-1:0] mem [MCTL_NCH][logic [28:0]];
  logic [28:0] wq [MCTL_NCH][$];
  int rq_due [MCTL_NCH][$];
  logic [MCTL_DW-1:0] rq_dat [MCTL_NCH][$];
  int cyc = 0;
  logic [MCTL_NCH-1:0][MCTL_DW-1:0] dq_r = '0;
  assign ch_dq_in = dq_r;
  always @(posedge clk_sys) begin
    for (int c = 0; c < MCTL_NCH; c++) begin
      if (ch_cmd[c] == MCTL_CMD_WR) wq[c].push_back({ch_bank[c], ch_row[c], ch_col[c]});
      // burst data lands whenever the controller drives it; timing is the controller's job
      if (ch_dq_oe[c] && wq[c].size() != 0) mem[c][wq[c].pop_front()] = ch_dq_out[c];
      if (ch_cmd[c] == MCTL_CMD_RD) begin
        rq_due[c].push_back(cyc + int'(cl[c]) - 2);
        rq_dat[c].push_back(mem[c][{ch_bank[c], ch_row[c], ch_col[c]}]);
      end
      // data stands for one cycle only; between bursts the bus toggles so nothing is held
      if (rq_due[c].size() != 0 && rq_due[c][0] == cyc) begin
        dq_r[c] <= rq_dat[c].pop_front();
        void'(rq_due[c].pop_front());
      end else begin
        dq_r[c] <= ~dq_r[c];
      end
    end
    cyc++;
  end
endmodule

// File: mctl_tb.sv
// self-checking testbench of the two-channel memory controller
`timescale 1ns/1ps
module testbench
  import mctl_pkg::*;
;
  // per config: ctrl, slots, caps (A not below B), latencies {ch1,ch0}, status [5:0]
  localparam logic [3:0] CF_CTRL [5] = '{4'h8, 4'h9, 4'hD, 4'hA, 4'h8};
  localparam logic [15:0] CF_SLOT [5] = '{16'h0001, 16'h0303, 16'h0393, 16'h1001, 16'h0100};
  localparam logic [31:0] CF_CAP [5] = '{32'h1, 32'h10001, 32'h10002, 32'h10001, 32'h1};
  localparam logic [9:0] CF_CL [5] = '{10'h0E7, 10'h129, 10'h0E9, 10'h0E7, 10'h0E7};
  localparam logic [9:0] CF_CWL [5] = '{10'h0C6, 10'h0E7, 10'h0C8, 10'h0C6, 10'h0C6};
  localparam logic [5:0] CF_STAT [5] = '{6'h08, 6'h11, 6'h02, 6'h16, 6'h08};
  logic clk_sys = 0, rst = 1, reg_we = 0, reg_re = 0, req_valid = 0, req_write = 0;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, req_addr = '0, rd, rs = 32'hC3A936A5, a;
  logic [63:0] req_wdata = '0;
  logic [3:0] req_tag = '0, tg = '0, ctrl_c;
  logic req_ready;
  logic [1:0] resp_valid, ch_dq_oe, two_n;
  logic [1:0][63:0] resp_data, ch_dq_out, ch_dq_in;
  logic [1:0][3:0] resp_tag;
  logic [1:0][2:0] ch_cmd, ch_bank, pcmd = '0;
  logic [1:0][15:0] ch_row;
  logic [1:0][9:0] ch_col;
  logic [1:0][4:0] cl_exp, cwl_exp;
  logic [15:0] slot_c;
  logic [31:0] cap_c, seed_c;
  logic [63:0] exp_d [16], refm [logic [28:0]], wexp [2][$];
  logic exp_c [16], ovl = 0;
  logic [31:0] addrs [$];
  int rq [2][$], wq [2][$];
  int err_count = 0, checked = 0, cyc = 0, pend = 0, k, n;
  always #20 clk_sys = ~clk_sys;
  mctl_two_channel_ctrl i_dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_we, .reg_re,
    .reg_rdata, .req_valid, .req_write, .req_addr, .req_wdata, .req_tag, .req_ready,
    .resp_valid, .resp_data, .resp_tag, .ch_cmd, .ch_bank, .ch_row, .ch_col, .ch_dq_out,
    .ch_dq_oe, .ch_dq_in);
  mctl_dram_model i_dram (.clk_sys, .ch_cmd, .ch_bank, .ch_row, .ch_col, .ch_dq_out,
    .ch_dq_oe, .cl(cl_exp), .ch_dq_in);
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic logic [63:0] key(logic [31:0] s, logic [31:0] o);
    logic [63:0] x;
    x = {s ^ o, o ^ ~s};
    x ^= x << 13;
    x ^= x >> 7;
    x ^= x << 17;
    return x;
  endfunction
  // {channel, offset}; the dual zone ends at twice the smaller capacity
  function automatic logic [32:0] map(logic [31:0] ad);
    logic p0, p1;
    logic [31:0] b;
    p0 = slot_c[0] | slot_c[4];
    p1 = slot_c[8] | slot_c[12];
    b = {cap_c[27:16], 20'h0};
    if (!(p0 && p1)) return {!p0 && p1, ad};
    if (ad < {b[30:0], 1'b0}) return {ad[6] ^ ctrl_c[2], 1'b0, ad[31:7], ad[5:0]};
    return {ctrl_c[2], ad - b};
  endfunction
  task automatic check(string nm, logic [63:0] e, logic [63:0] s);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic reg_wr(logic [7:0] ad, logic [31:0] d);
    @(posedge clk_sys);
    reg_we <= 1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_we <= 0;
  endtask
  task automatic reg_rd(logic [7:0] ad);
    @(posedge clk_sys);
    reg_re <= 1;
    reg_addr <= ad;
    @(posedge clk_sys);
    reg_re <= 0;
    #1 rd = reg_rdata;
  endtask
  task automatic host(logic w, logic [31:0] ad, logic [63:0] d);
    logic [32:0] m;
    int t;
    m = map(ad);
    @(posedge clk_sys);
    req_valid <= 1;
    req_write <= w;
    req_addr <= ad;
    req_wdata <= d;
    req_tag <= tg;
    t = 0;
    do begin @(negedge clk_sys); t++; end while (!req_ready && t < 500);
    check("request accepted", 1, req_ready);
    @(posedge clk_sys);
    req_valid <= 0;
    if (w) begin
      refm[ad[31:3]] = d;
      wexp[m[32]].push_back(d ^ key(seed_c, m[31:0]));
      addrs.push_back(ad);
    end else begin
      exp_d[tg] = refm[ad[31:3]];
      exp_c[tg] = m[32];
      pend++;
      tg++;
    end
  endtask
  function automatic logic [31:0] gen(logic [31:0] r);
    return (r & 32'h0003FFF8) | ((k == 2 && r[20]) ? 32'h00200000 : 32'h0);
  endfunction
  always @(posedge clk_sys) begin
    int j;
    if (!rst) for (int c = 0; c < 2; c++) begin
      if (ch_cmd[c] == MCTL_CMD_RD) rq[c].push_back(cyc);
      if (ch_cmd[c] == MCTL_CMD_WR) wq[c].push_back(cyc);
      if (two_n[c] && ch_cmd[c] != 0 && pcmd[c] != 0) check("cmd spacing", 0, 1);
      pcmd[c] = ch_cmd[c];
      if (resp_valid[c]) begin
        check("resp channel", exp_c[resp_tag[c]], c);
        check("resp data", exp_d[resp_tag[c]], resp_data[c]);
        if (rq[c].size() != 0) check("read latency", cl_exp[c], cyc - rq[c].pop_front());
        pend--;
      end
      if (ch_dq_oe[c]) begin
        j = -1;
        for (int i = 0; i < wexp[c].size(); i++) if (j < 0 && wexp[c][i] === ch_dq_out[c]) j = i;
        check("scrambled write", 1, j >= 0);
        if (j >= 0) wexp[c].delete(j);
        if (wq[c].size() != 0) begin
          check("write latency", cwl_exp[c], cyc - wq[c].pop_front());
        end
      end
      if (rq[0].size() != 0 && rq[1].size() != 0) ovl = 1;
    end
    cyc++;
    // the ceiling ends the run from here, so nothing may follow it in this block
    if (cyc == 60000) begin
      err_count++;
      results();
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 0;
    reg_rd(MCTL_REG_CTRL);
    check("ctrl reset", 0, rd);
    reg_rd(8'h40);
    check("unmapped read", 0, rd);
    for (k = 0; k < 5; k++) begin
      ctrl_c = CF_CTRL[k];
      slot_c = CF_SLOT[k];
      cap_c = CF_CAP[k];
      seed_c = rnd();
      cl_exp = CF_CL[k];
      cwl_exp = CF_CWL[k];
      two_n = CF_STAT[k][2:1];
      refm.delete();
      addrs.delete();
      reg_wr(MCTL_REG_SLOT, {16'h0, slot_c});
      reg_wr(MCTL_REG_CAP, cap_c);
      reg_wr(MCTL_REG_SEED, seed_c);
      reg_wr(MCTL_REG_CTRL, {28'h0, ctrl_c});
      reg_rd(MCTL_REG_SEED);
      check("seed readback", seed_c, rd);
      reg_rd(MCTL_REG_STAT);
      check("status", CF_STAT[k], rd[5:0]);
      for (int i = 0; i < 24; i++) begin
        rd = rnd();
        if (addrs.size() < 4 || rd[0]) host(1, gen(rd), {rnd(), rnd()});
        else host(0, addrs[rd[15:8] % addrs.size()], 64'h0);
      end
      // neighbouring lines, then a read right behind a write to the same word
      a = gen(rnd());
      host(1, a, {rnd(), rnd()});
      host(1, a ^ 32'h40, {rnd(), rnd()});
      host(0, a, 64'h0);
      host(0, a ^ 32'h40, 64'h0);
      host(1, a, {rnd(), rnd()});
      host(0, a, 64'h0);
      n = 0;
      // drain writes too: a seed change with a write still queued would rescramble it
      while ((pend != 0 || wexp[0].size() + wexp[1].size() != 0) && n < 3000) begin
        @(posedge clk_sys);
        n++;
      end
      check("reads returned", 0, pend);
      repeat (4) @(posedge clk_sys);
      check("writes on bus", 0, wexp[0].size() + wexp[1].size());
      if (k == 1) check("channel overlap", 1, ovl);
      $display("config %0d done", k);
    end
    results();
  end
endmodule
